// ---- common/fmsr_pkg.sv ----
// Constants, types and field layout shared by the fault, mask and status register bank.
// Assumes a single 200 MHz clock and an active-low reset released synchronously by the top.
// Behaviour
// - Machine-error request is the OR of all sixteen fault bits.
// - No enable or mask can suppress the machine-error request.
// - Fault bits that are not implemented always hold and read zero.
// - Software reads, writes and clears the fault register with register instructions.
// - Externally driven fault bits cannot be cleared while their input stays asserted.
// - Bit 15 sets on memory-protect while the processor owns the bus; resets zero.
// - Bit 14 sets on memory-protect while the processor does not own the bus.
// - Bits 13 and 8 set on the two user machine-error inputs.
// - Bit 10 sets on bus error during a processor I/O access.
// - Bit 7 sets on bus error during a processor memory access.
// - Bits 12, 11, 9, 6..0 are software error flags feeding the request.
// - Mask register holds one software read/write bit per interrupt source.
// - Mask bits 15 and 10 have no effect; those sources are never masked.
// - A mask one lets its source through; a mask zero blocks it.
// - Mask bit 0 belongs to no source and affects nothing.
// - Status bits 15..12 show carry, positive, zero and negative flags.
// - Status bits 7..0 drive output discrete lines 7..0.
// - Software reads and writes the status register to restore the flags.
package fmsr_pkg;

    localparam int unsigned REG_WIDTH = 16;
    localparam int unsigned FLAG_WIDTH = 4;
    localparam int unsigned USER_WIDTH = 4;
    localparam int unsigned DISCRETE_WIDTH = 8;

    // Fault register bit positions.
    localparam int unsigned FAULT_CPU_PROTECT = 15;
    localparam int unsigned FAULT_DMA_PROTECT = 14;
    localparam int unsigned FAULT_USER_ERROR_B = 13;
    localparam int unsigned FAULT_IO_TIMEOUT = 10;
    localparam int unsigned FAULT_USER_ERROR_A = 8;
    localparam int unsigned FAULT_MEM_TIMEOUT = 7;

    // Every fault position has a flip-flop; a zero here would tie that bit low.
    localparam logic [15:0] FAULT_IMPLEMENTED = 16'hffff;

    // Mask bits that cannot mask and the bit that has no source.
    localparam int unsigned MASK_POWER_FAIL = 15;
    localparam int unsigned MASK_SOFT_TWO = 10;
    localparam int unsigned MASK_UNUSED = 0;

    // Status register field positions.
    localparam int unsigned STATUS_FLAGS_LSB = 12;
    localparam int unsigned STATUS_USER_LSB = 8;
    localparam int unsigned STATUS_DISCRETE_LSB = 0;

    // Values after reset.
    localparam logic [15:0] FAULT_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] USER_RESET = 4'h0;
    localparam logic [7:0] DISCRETE_RESET = 8'h00;

    // Cycles from a taken read request to its answer.
    localparam int unsigned READ_LATENCY = 1;

    typedef enum logic [1:0] {
        FMSR_SEL_FAULT,
        FMSR_SEL_MASK,
        FMSR_SEL_STATUS,
        FMSR_SEL_NONE
    } fmsr_sel_t;

    typedef enum logic [1:0] {
        FMSR_OP_IDLE,
        FMSR_OP_READ,
        FMSR_OP_WRITE,
        FMSR_OP_CLEAR
    } fmsr_op_t;

    // One register-transfer instruction from the processor core.
    typedef struct packed {
        fmsr_op_t op;
        fmsr_sel_t sel;
        logic [15:0] data;
    } fmsr_req_t;

    // Conditions on the operand port that can raise hardware faults.
    typedef struct packed {
        logic cpu_owns_bus;
        logic cpu_access;
        logic access_is_io;
        logic memory_protect_input;
        logic bus_error_input;
        logic user_machine_error_a;
        logic user_machine_error_b;
    } fmsr_fault_in_t;

endpackage

// ---- rtl/fmsr_fault_bit.sv ----
// One fault register bit with hardware set, software load and software clear.
// Assumes a synchronised active-low reset and requests that last one cycle.
`timescale 1ns/1ps
`default_nettype none
module fmsr_fault_bit #(
    parameter bit IMPLEMENTED = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hw_set,
    input wire logic sw_write,
    input wire logic sw_clear,
    input wire logic sw_data,
    output logic bit_next,
    output logic bit_reg
);

    // A live hardware condition wins over any write or clear in the same cycle.
    always_comb begin
        if (!IMPLEMENTED) begin
            bit_next = 1'b0;
        end else if (hw_set) begin
            bit_next = 1'b1;
        end else if (sw_write) begin
            bit_next = sw_data;
        end else if (sw_clear && sw_data) begin
            bit_next = 1'b0;
        end else begin
            bit_next = bit_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_reg <= 1'b0;
        end else begin
            bit_reg <= bit_next;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/fmsr_regs.sv ----
// Fault, interrupt mask and status/output-discrete registers of the processor.
// Assumes register instructions arrive as one-cycle requests synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module fmsr_regs (
    input wire logic clock,
    input wire logic rst_b,
    input wire fmsr_pkg::fmsr_req_t req,
    input wire fmsr_pkg::fmsr_fault_in_t fault_in,
    input wire logic flags_load,
    input wire logic [3:0] flags_in,
    input wire logic [15:0] raw_interrupts,
    output logic [15:0] read_data_reg,
    output logic read_valid_reg,
    output logic machine_error_request_reg,
    output logic [15:0] effective_mask_reg,
    output logic [15:0] unmasked_interrupts_reg,
    output logic [3:0] cond_flags_reg,
    output logic [7:0] output_discrete_lines_reg
);

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic [15:0] fault_reg;
    logic [15:0] fault_next;
    logic [15:0] hw_set;
    logic [15:0] interrupt_enable_mask_reg;
    logic [15:0] mask_next;
    logic [3:0] user_bits_reg;
    logic [15:0] status_view;
    logic [15:0] read_next;
    logic fault_write;
    logic fault_clear;
    logic mask_write;
    logic status_write;

    // Asynchronous assertion, release through two flip-flops.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign fault_write = (req.op == fmsr_pkg::FMSR_OP_WRITE) &&
        (req.sel == fmsr_pkg::FMSR_SEL_FAULT);
    assign fault_clear = (req.op == fmsr_pkg::FMSR_OP_CLEAR) &&
        (req.sel == fmsr_pkg::FMSR_SEL_FAULT);
    assign mask_write = (req.op == fmsr_pkg::FMSR_OP_WRITE) &&
        (req.sel == fmsr_pkg::FMSR_SEL_MASK);
    assign status_write = (req.op == fmsr_pkg::FMSR_OP_WRITE) &&
        (req.sel == fmsr_pkg::FMSR_SEL_STATUS);

    // Hardware fault sources; unlisted positions are software flags only.
    always_comb begin
        hw_set = 16'h0000;
        hw_set[fmsr_pkg::FAULT_CPU_PROTECT] =
            fault_in.memory_protect_input && fault_in.cpu_owns_bus;
        hw_set[fmsr_pkg::FAULT_DMA_PROTECT] =
            fault_in.memory_protect_input && !fault_in.cpu_owns_bus;
        hw_set[fmsr_pkg::FAULT_USER_ERROR_B] = fault_in.user_machine_error_b;
        hw_set[fmsr_pkg::FAULT_USER_ERROR_A] = fault_in.user_machine_error_a;
        hw_set[fmsr_pkg::FAULT_IO_TIMEOUT] = fault_in.bus_error_input &&
            fault_in.cpu_owns_bus && fault_in.cpu_access && fault_in.access_is_io;
        hw_set[fmsr_pkg::FAULT_MEM_TIMEOUT] = fault_in.bus_error_input &&
            fault_in.cpu_owns_bus && fault_in.cpu_access && !fault_in.access_is_io;
    end

    generate
        for (genvar i = 0; i < 16; i++) begin : g_fault
            fmsr_fault_bit #(
                .IMPLEMENTED(fmsr_pkg::FAULT_IMPLEMENTED[i])
            ) u_bit (
                .clock(clock),
                .rst_n(rst_sync_reg),
                .hw_set(hw_set[i]),
                .sw_write(fault_write),
                .sw_clear(fault_clear),
                .sw_data(req.data[i]),
                .bit_next(fault_next[i]),
                .bit_reg(fault_reg[i])
            );
        end
    endgenerate

    // The request follows the next fault value so it lines up with the register.
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            machine_error_request_reg <= 1'b0;
        end else begin
            machine_error_request_reg <= |fault_next;
        end
    end

    assign mask_next = mask_write ? req.data : interrupt_enable_mask_reg;

    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            interrupt_enable_mask_reg <= fmsr_pkg::MASK_RESET;
        end else begin
            interrupt_enable_mask_reg <= mask_next;
        end
    end

    // Stored bits read back as written; the effective copy forces the fixed positions.
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            effective_mask_reg <= 16'h8400;
        end else begin
            effective_mask_reg <= mask_next;
            effective_mask_reg[fmsr_pkg::MASK_POWER_FAIL] <= 1'b1;
            effective_mask_reg[fmsr_pkg::MASK_SOFT_TWO] <= 1'b1;
            effective_mask_reg[fmsr_pkg::MASK_UNUSED] <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            unmasked_interrupts_reg <= 16'h0000;
        end else begin
            unmasked_interrupts_reg <= raw_interrupts & effective_mask_reg;
        end
    end

    // A software restore of the flags wins over an ALU update in the same cycle.
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            cond_flags_reg <= fmsr_pkg::FLAGS_RESET;
        end else if (status_write) begin
            cond_flags_reg <= req.data[15:12];
        end else if (flags_load) begin
            cond_flags_reg <= flags_in;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            user_bits_reg <= fmsr_pkg::USER_RESET;
        end else if (status_write) begin
            user_bits_reg <= req.data[11:8];
        end
    end

    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            output_discrete_lines_reg <= fmsr_pkg::DISCRETE_RESET;
        end else if (status_write) begin
            output_discrete_lines_reg <= req.data[7:0];
        end
    end

    assign status_view = {cond_flags_reg, user_bits_reg, output_discrete_lines_reg};

    always_comb begin
        unique case (req.sel)
            fmsr_pkg::FMSR_SEL_FAULT: read_next = fault_reg;
            fmsr_pkg::FMSR_SEL_MASK: read_next = interrupt_enable_mask_reg;
            fmsr_pkg::FMSR_SEL_STATUS: read_next = status_view;
            fmsr_pkg::FMSR_SEL_NONE: read_next = 16'h0000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            read_data_reg <= 16'h0000;
            read_valid_reg <= 1'b0;
        end else begin
            read_valid_reg <= (req.op == fmsr_pkg::FMSR_OP_READ);
            if (req.op == fmsr_pkg::FMSR_OP_READ) begin
                read_data_reg <= read_next;
            end
        end
    end

    mce_or_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        machine_error_request_reg == (|fault_reg))
        else $error("machine error request differs from OR of fault bits");

    mce_nomask_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        ((fault_reg != 16'h0000) && (interrupt_enable_mask_reg == 16'h0000))
        |-> machine_error_request_reg)
        else $error("machine error request suppressed by mask");

    fault_unimpl_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (fault_reg & ~fmsr_pkg::FAULT_IMPLEMENTED) == 16'h0000)
        else $error("unimplemented fault bit set");

    fault_write_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (fault_write && (hw_set == 16'h0000)) |=> (fault_reg == $past(req.data)))
        else $error("fault register write not stored");

    fault_clear_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (fault_clear && (hw_set == 16'h0000))
        |=> (fault_reg == ($past(fault_reg) & ~$past(req.data))))
        else $error("fault register clear wrong");

    level_hold_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (fault_in.user_machine_error_b && fault_clear)
        |=> fault_reg[fmsr_pkg::FAULT_USER_ERROR_B])
        else $error("external fault cleared while input asserted");

    cpu_protect_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (fault_in.memory_protect_input && fault_in.cpu_owns_bus)
        |=> (fault_reg[fmsr_pkg::FAULT_CPU_PROTECT] &&
            (!fault_reg[fmsr_pkg::FAULT_DMA_PROTECT] ||
            $past(fault_reg[fmsr_pkg::FAULT_DMA_PROTECT]) || $past(fault_write))))
        else $error("processor protect fault not captured");

    dma_protect_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (fault_in.memory_protect_input && !fault_in.cpu_owns_bus)
        |=> fault_reg[fmsr_pkg::FAULT_DMA_PROTECT])
        else $error("dma protect fault not captured");

    user_error_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        fault_in.user_machine_error_a |=> fault_reg[fmsr_pkg::FAULT_USER_ERROR_A])
        else $error("user machine error a not captured");

    io_timeout_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (fault_in.bus_error_input && fault_in.cpu_owns_bus && fault_in.cpu_access &&
            fault_in.access_is_io) |=> fault_reg[fmsr_pkg::FAULT_IO_TIMEOUT])
        else $error("io timeout fault not captured");

    mem_timeout_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (fault_in.bus_error_input && fault_in.cpu_owns_bus && fault_in.cpu_access &&
            !fault_in.access_is_io) |=> fault_reg[fmsr_pkg::FAULT_MEM_TIMEOUT])
        else $error("memory timeout fault not captured");

    soft_flag_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (fault_write && req.data[0]) |=> (fault_reg[0] && machine_error_request_reg))
        else $error("software fault flag does not raise request");

    mask_write_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        mask_write |=> ((interrupt_enable_mask_reg == $past(req.data)) &&
            ((effective_mask_reg & 16'h7bfe) == ($past(req.data) & 16'h7bfe))))
        else $error("mask write not stored");

    mask_fixed_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        effective_mask_reg[fmsr_pkg::MASK_POWER_FAIL] &&
        effective_mask_reg[fmsr_pkg::MASK_SOFT_TWO])
        else $error("unmaskable source became masked");

    mask_gate_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        ##1 (unmasked_interrupts_reg ==
            ($past(raw_interrupts) & $past(effective_mask_reg))))
        else $error("interrupt gating wrong");

    mask_unused_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        !unmasked_interrupts_reg[fmsr_pkg::MASK_UNUSED])
        else $error("unused interrupt position passed");

    status_read_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        ((req.op == fmsr_pkg::FMSR_OP_READ) && (req.sel == fmsr_pkg::FMSR_SEL_STATUS))
        |=> (read_valid_reg && (read_data_reg[15:12] == $past(cond_flags_reg))))
        else $error("status read does not show condition flags");

    discrete_out_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        status_write |=> (output_discrete_lines_reg == $past(req.data[7:0])))
        else $error("output discretes not driven from status write");

    flag_restore_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (status_write && flags_load) |=> (cond_flags_reg == $past(req.data[15:12])))
        else $error("status write did not restore flags");

    user_store_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        status_write |=> (status_view[11:8] == $past(req.data[11:8])))
        else $error("user bits not stored");

    fault_sticky_a: assert property (
        @(posedge clock) disable iff (!rst_sync_reg)
        (fault_reg[fmsr_pkg::FAULT_CPU_PROTECT] && !fault_write && !fault_clear)
        |=> fault_reg[fmsr_pkg::FAULT_CPU_PROTECT])
        else $error("fault bit dropped without software clear");

endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the fault, mask and status register bank.
// Assumes the register bank package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); \
        end \
    end
module tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    fmsr_pkg::fmsr_req_t req = '0;
    fmsr_pkg::fmsr_fault_in_t fault_in = '0;
    logic flags_load = 1'b0;
    logic [3:0] flags_in = 4'h0;
    logic [15:0] raw_interrupts = 16'h0000;
    logic [15:0] read_data_reg;
    logic read_valid_reg;
    logic machine_error_request_reg;
    logic [15:0] effective_mask_reg;
    logic [15:0] unmasked_interrupts_reg;
    logic [3:0] cond_flags_reg;
    logic [7:0] output_discrete_lines_reg;
    int bad_count = 0;
    int compares = 0;

    fmsr_regs i_fmsr_regs (
        .clock(clock),
        .rst_b(rst_b),
        .req(req),
        .fault_in(fault_in),
        .flags_load(flags_load),
        .flags_in(flags_in),
        .raw_interrupts(raw_interrupts),
        .read_data_reg(read_data_reg),
        .read_valid_reg(read_valid_reg),
        .machine_error_request_reg(machine_error_request_reg),
        .effective_mask_reg(effective_mask_reg),
        .unmasked_interrupts_reg(unmasked_interrupts_reg),
        .cond_flags_reg(cond_flags_reg),
        .output_discrete_lines_reg(output_discrete_lines_reg)
    );

    always #2.5 clock = ~clock;

    task automatic step();
        @(posedge clock);
        #1;
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One register instruction, then one idle edge so that calls in a row never reassign req.
    task automatic op(input fmsr_pkg::fmsr_op_t o, input fmsr_pkg::fmsr_sel_t s,
                      input logic [15:0] d);
        req = '{op: o, sel: s, data: d};
        step();
        req = '0;
        step();
    endtask

    // The valid flag stands only in the cycle after the taking edge, so the answer is read there.
    task automatic rd(input fmsr_pkg::fmsr_sel_t s, output logic [15:0] v);
        req = '{op: fmsr_pkg::FMSR_OP_READ, sel: s, data: 16'h0000};
        step();
        req = '0;
        `CHECK(read_valid_reg, 1'b1);
        v = read_data_reg;
        step();
    endtask

    task automatic reset_dut();
        rst_b = 1'b0;
        repeat (4) step();
        rst_b = 1'b1;
        repeat (3) step();
    endtask

    task automatic test_reset();
        logic [15:0] v;
        `CHECK(machine_error_request_reg, 1'b0);
        `CHECK(effective_mask_reg, 16'h8400);
        `CHECK(cond_flags_reg, 4'h0);
        `CHECK(output_discrete_lines_reg, 8'h00);
        rd(fmsr_pkg::FMSR_SEL_FAULT, v);
        `CHECK(v, 16'h0000);
        rd(fmsr_pkg::FMSR_SEL_MASK, v);
        `CHECK(v, 16'h0000);
        rd(fmsr_pkg::FMSR_SEL_STATUS, v);
        `CHECK(v, 16'h0000);
        $display("reset values done");
    endtask

    // Every fault bit alone must raise the request even though the mask is all zero.
    task automatic test_soft();
        logic [15:0] v;
        logic [15:0] m;
        for (int i = 0; i < 16; i++) begin
            m = 16'h0001 << i;
            op(fmsr_pkg::FMSR_OP_WRITE, fmsr_pkg::FMSR_SEL_FAULT, m);
            rd(fmsr_pkg::FMSR_SEL_FAULT, v);
            `CHECK(v, m);
            `CHECK(machine_error_request_reg, 1'b1);
            op(fmsr_pkg::FMSR_OP_CLEAR, fmsr_pkg::FMSR_SEL_FAULT, m);
            rd(fmsr_pkg::FMSR_SEL_FAULT, v);
            `CHECK(v, 16'h0000);
            `CHECK(machine_error_request_reg, 1'b0);
        end
        op(fmsr_pkg::FMSR_OP_WRITE, fmsr_pkg::FMSR_SEL_FAULT, 16'h1a7f);
        op(fmsr_pkg::FMSR_OP_CLEAR, fmsr_pkg::FMSR_SEL_FAULT, 16'h0a0f);
        rd(fmsr_pkg::FMSR_SEL_FAULT, v);
        `CHECK(v, 16'h1070);
        op(fmsr_pkg::FMSR_OP_WRITE, fmsr_pkg::FMSR_SEL_FAULT, 16'h0000);
        step();
        `CHECK(machine_error_request_reg, 1'b0);
        $display("software fault flags done");
    endtask

    // Each cause is held through a clear attempt, then dropped, then the bit is cleared.
    task automatic test_hw();
        logic [15:0] v;
        logic [6:0] cause [7] = '{7'h48, 7'h08, 7'h01, 7'h02, 7'h74, 7'h64, 7'h54};
        logic [15:0] hit [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h0100, 16'h0400,
                                 16'h0080, 16'h0000};
        for (int i = 0; i < 7; i++) begin
            fault_in = fmsr_pkg::fmsr_fault_in_t'(cause[i]);
            step();
            op(fmsr_pkg::FMSR_OP_CLEAR, fmsr_pkg::FMSR_SEL_FAULT, 16'hffff);
            rd(fmsr_pkg::FMSR_SEL_FAULT, v);
            `CHECK(v, hit[i]);
            `CHECK(machine_error_request_reg, |hit[i]);
            fault_in = '0;
            step();
            rd(fmsr_pkg::FMSR_SEL_FAULT, v);
            `CHECK(v, hit[i]);
            op(fmsr_pkg::FMSR_OP_CLEAR, fmsr_pkg::FMSR_SEL_FAULT, 16'hffff);
            rd(fmsr_pkg::FMSR_SEL_FAULT, v);
            `CHECK(v, 16'h0000);
        end
        $display("hardware fault sources done");
    endtask

    task automatic test_mask();
        logic [15:0] v;
        logic [15:0] eff;
        logic [15:0] masks [4] = '{16'h0000, 16'hffff, 16'h5a5a, 16'h0401};
        raw_interrupts = 16'hffff;
        for (int i = 0; i < 4; i++) begin
            eff = (masks[i] | 16'h8400) & 16'hfffe;
            op(fmsr_pkg::FMSR_OP_WRITE, fmsr_pkg::FMSR_SEL_MASK, masks[i]);
            `CHECK(effective_mask_reg, eff);
            `CHECK(unmasked_interrupts_reg, eff);
            rd(fmsr_pkg::FMSR_SEL_MASK, v);
            `CHECK(v, masks[i]);
        end
        raw_interrupts = 16'h0c03;
        step();
        `CHECK(unmasked_interrupts_reg, 16'h0400);
        raw_interrupts = 16'h0000;
        $display("interrupt mask done");
    endtask

    task automatic test_status();
        logic [15:0] v;
        logic [7:0] b;
        op(fmsr_pkg::FMSR_OP_WRITE, fmsr_pkg::FMSR_SEL_STATUS, 16'hab5c);
        `CHECK(cond_flags_reg, 4'ha);
        `CHECK(output_discrete_lines_reg, 8'h5c);
        rd(fmsr_pkg::FMSR_SEL_STATUS, v);
        `CHECK(v, 16'hab5c);
        flags_load = 1'b1;
        flags_in = 4'h3;
        step();
        flags_load = 1'b0;
        `CHECK(cond_flags_reg, 4'h3);
        rd(fmsr_pkg::FMSR_SEL_STATUS, v);
        `CHECK(v, 16'h3b5c);
        flags_load = 1'b1;
        flags_in = 4'hf;
        req = '{op: fmsr_pkg::FMSR_OP_WRITE, sel: fmsr_pkg::FMSR_SEL_STATUS, data: 16'h6000};
        step();
        flags_load = 1'b0;
        req = '0;
        `CHECK(cond_flags_reg, 4'h6);
        step();
        for (int n = 0; n < 8; n++) begin
            b = 8'h01 << n;
            op(fmsr_pkg::FMSR_OP_WRITE, fmsr_pkg::FMSR_SEL_STATUS, {8'h00, b});
            `CHECK(output_discrete_lines_reg, b);
        end
        $display("status and discretes done");
    endtask

    task automatic test_none();
        logic [15:0] v;
        op(fmsr_pkg::FMSR_OP_WRITE, fmsr_pkg::FMSR_SEL_FAULT, 16'h0003);
        op(fmsr_pkg::FMSR_OP_WRITE, fmsr_pkg::FMSR_SEL_NONE, 16'hffff);
        op(fmsr_pkg::FMSR_OP_CLEAR, fmsr_pkg::FMSR_SEL_MASK, 16'hffff);
        rd(fmsr_pkg::FMSR_SEL_NONE, v);
        `CHECK(v, 16'h0000);
        rd(fmsr_pkg::FMSR_SEL_FAULT, v);
        `CHECK(v, 16'h0003);
        rd(fmsr_pkg::FMSR_SEL_MASK, v);
        `CHECK(v, 16'h0401);
        $display("unselected and ignored requests done");
    endtask

    initial begin
        #100000;
        bad_count++;
        $display("run took too long");
        stop_test();
    end

    initial begin
        reset_dut();
        test_reset();
        test_soft();
        test_hw();
        test_mask();
        test_status();
        test_none();
        reset_dut();
        test_reset();
        stop_test();
    end
endmodule
`default_nettype wire
